// *** core/qa_watchdog_status_regs.sv ***
// Purpose: Watchdog timer with question-and-answer checking, transceiver status
//          and interrupt summary registers.
// Assumes: Register frames arrive already decoded as one-cycle address strobes.
// Notes:   Read data appears one cycle after the read strobe.
//
// Contract
// - Three-bit duration field, bits 7-5, reset zero.
// - Read-only fault counter bits 4-1, resets one.
// - Kick byte FFh restarts timer when permitted.
// - QA setup fields 7-6, 5-4, 3-0, writable.
// - Seed loads into generator only while idle.
// - Seed reads zero, effective 101b until written.
// - Host writes full answer byte, checked.
// - Answer error flag bit 6, write-one clears.
// - Answer counter bits 5-4, three on enable.
// - Question bits 3-0, reads C on enable.
// - Bit 0 shows transmit-low blocking active mode.
// - Status at 40h: active bit 3, quiet 2.
// - Summary at 50h, bits 7-3 OR flags.
// - Bit 7 all, bits 6-3 per group.
// - Watchdog runs only when enable bit set.
// - Prescaler codes give factor one to four.
// - Style codes auto, timeout, window, QA.
`timescale 1ns/10ps
module qa_watchdog_status_regs #(
    parameter int unsigned TICK_DIV   = wdog_pkg::TICK_CYCLES,
    parameter int unsigned STEP_TICKS = wdog_pkg::BASE_TICKS
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire wdog_pkg::reg_req_t     regReq,
    input  wire wdog_pkg::xcvr_status_t xcvrIn,
    input  wire wdog_pkg::irq_groups_t  irqIn,
    output logic [7:0]                  regRdData,
    output logic                        regRdValid,
    output logic                        wdogFaultPulse,
    output logic                        wdogRunning
);
    import wdog_pkg::*;

    // Write decode, used for every writable register.
    function automatic logic wrHit(input reg_req_t q, input logic [7:0] ofs);
        wrHit = q.wrEn && (q.addr == ofs);
    endfunction : wrHit

    // Next value of the question generator for the selected polynomial.
    function automatic logic [3:0] lfsrStep(input logic [3:0] v, input logic [1:0] sel);
        logic [3:0] taps;
        logic [3:0] nv;
        taps = (sel == 2'h0) ? 4'h9 : (sel == 2'h1) ? 4'hC : (sel == 2'h2) ? 4'h3 : 4'hA;
        nv   = {v[2:0], ^(v & taps)};
        // An all-zero state would lock the generator, so it is steered away.
        lfsrStep = (nv == 4'h0) ? 4'h1 : nv;
    endfunction : lfsrStep

    // Expected answer for a question and the answer still outstanding.
    function automatic logic [7:0] answerFor(input logic [3:0] chal, input logic [1:0] cnt,
                                             input logic [1:0] gen);
        answerFor = {(~chal) ^ {gen, cnt}, chal};
    endfunction : answerFor

    // Configuration and state registers.
    wdog_style_t wdogStyle_r;
    logic [1:0]  wdogScale_r;
    logic [1:0]  errCntSet_r;
    logic        wdogOn_r;
    logic [2:0]  durSel_r;
    logic [3:0]  faultCnt_r;
    logic [1:0]  respGen_r;
    logic [1:0]  polySel_r;
    logic [3:0]  seedShown_r;
    logic [3:0]  seedEff_r;
    logic [7:0]  respByte_r;
    logic        respFault_r;
    logic [1:0]  respCnt_r;
    logic [3:0]  challenge_r;
    logic [3:0]  lfsr_r;
    wdog_state_t state_r;
    logic [15:0] tickDiv_r;
    logic [11:0] tickCnt_r;
    xcvr_status_t xcvr_r;
    logic [7:0]  irqSum_r;
    logic [7:0]  regRdData_r;
    logic        regRdValid_r;
    logic        wdogFault_r;

    // Next values.
    logic [15:0] tickDiv_nxt;
    logic [11:0] tickCnt_nxt;
    wdog_state_t state_nxt;
    logic [3:0]  faultCnt_nxt;
    logic        respFault_nxt;
    logic [1:0]  respCnt_nxt;
    logic [3:0]  challenge_nxt;
    logic [3:0]  lfsr_nxt;
    logic [7:0]  irqSum_nxt;
    logic [7:0]  regRdData_nxt;

    // Decoded strobes.
    wire wrSetup  = wrHit(regReq, OFS_WD_SETUP);
    wire wrTiming = wrHit(regReq, OFS_WD_TIMING);
    wire wrKick   = wrHit(regReq, OFS_KICK);
    wire wrQaSet  = wrHit(regReq, OFS_QA_SETUP);
    wire wrResp   = wrHit(regReq, OFS_QA_RESP);
    wire wrChal   = wrHit(regReq, OFS_QA_CHAL);

    // Run state follows the enable bit; idle is the generator's reset state.
    wire running  = (state_r == WD_RUN);
    wire enterRun = (state_r == WD_IDLE) && wdogOn_r;
    assign state_nxt = wdogOn_r ? WD_RUN : WD_IDLE;

    // Period length in ticks: duration step times prescale factor.
    wire [11:0] durTerm   = 12'(durSel_r) + 12'h001;
    wire [11:0] scaleTerm = 12'(wdogScale_r) + 12'h001;
    wire [11:0] limit     = 12'(durTerm * scaleTerm * 12'(STEP_TICKS));
    wire [11:0] halfLimit = {1'b0, limit[11:1]};

    // Tick divider gives a one-cycle enable for the period counter.
    wire tickPulse = (tickDiv_r == 16'(TICK_DIV - 1));
    assign tickDiv_nxt = (!running || tickPulse) ? 16'h0000 : tickDiv_r + 16'h0001;

    // Service and fault events.
    wire qaStyle    = (wdogStyle_r == STYLE_QA);
    wire kickWr     = wrKick && running && !qaStyle
                      && (regReq.wrData == KICK_BYTE);
    wire earlyKick  = kickWr && (wdogStyle_r == STYLE_WINDOW)
                      && (tickCnt_r < halfLimit);
    wire goodKick   = kickWr && !earlyKick;
    wire expired    = running && tickPulse && (tickCnt_r >= limit - 12'h001);
    wire answerWr   = wrResp && running && qaStyle;
    wire answerOk   = regReq.wrData == answerFor(challenge_r, respCnt_r, respGen_r);
    wire badAnswer  = answerWr && !answerOk;
    wire lastGood   = answerWr && answerOk && (respCnt_r == 2'h0);
    wire faultEvt   = expired || earlyKick || badAnswer;
    wire restart    = goodKick || lastGood || expired || earlyKick;

    // Period counter restarts on service, on expiry or on an early kick (not on a wrong answer), never runs when idle.
    assign tickCnt_nxt = (!running || restart) ? 12'h000 :
                         tickPulse ? tickCnt_r + 12'h001 : tickCnt_r;

    // Fault counter counts up and holds at its ceiling.
    assign faultCnt_nxt = (faultEvt && (faultCnt_r != FAULT_CNT_MAX)) ?
                          faultCnt_r + 4'h1 : faultCnt_r;

    // A new answer error wins over a clear in the same cycle.
    assign respFault_nxt = badAnswer ? 1'b1 :
                           (wrChal && regReq.wrData[POS_RESPERR]) ? 1'b0 :
                           respFault_r;

    // Answer counter counts down per good answer and reloads after the last.
    assign respCnt_nxt = enterRun ? RESP_CNT_START :
                         !running ? respCnt_r :
                         (answerWr && answerOk) ?
                         ((respCnt_r == 2'h0) ? RESP_CNT_START : respCnt_r - 2'h1) :
                         respCnt_r;

    // Question shows C on enable, then takes the generator value per round.
    assign challenge_nxt = enterRun ? CHAL_ON_ENABLE :
                           lastGood ? lfsr_r : challenge_r;

    // The generator takes the seed only while idle, so a seed write in operation
    // cannot disturb a round in progress.
    assign lfsr_nxt = !running ? seedEff_r :
                      lastGood ? lfsrStep(lfsr_r, polySel_r) : lfsr_r;

    // Interrupt summary: one bit per group and one for everything.
    wire sumG1 = |irqIn.grp1;
    wire sumG2 = |irqIn.grp2;
    wire sumG3 = |irqIn.grp3;
    wire sumBf = |irqIn.busFault;
    assign irqSum_nxt = {sumG1 | sumG2 | sumG3 | sumBf,
                         sumG1, sumG2, sumG3, sumBf, 3'b000};

    // Read images of each register; reserved bits read as zero.
    wire [7:0] imgSetup  = {wdogStyle_r, wdogScale_r, errCntSet_r, 1'b0, wdogOn_r};
    wire [7:0] imgTiming = {durSel_r, faultCnt_r, 1'b0};
    wire [7:0] imgQaSet  = {respGen_r, polySel_r, seedShown_r};
    wire [7:0] imgChal   = {1'b0, respFault_r, respCnt_r, challenge_r};
    wire [7:0] imgXcvr   = {4'h0, xcvr_r.canActive, xcvr_r.busQuiet,
                            1'b0, xcvr_r.txLowBlock};

    // Read selection; the kick register always reads zero, unmapped reads zero.
    assign regRdData_nxt = (regReq.addr == OFS_WD_SETUP)  ? imgSetup  :
                           (regReq.addr == OFS_WD_TIMING) ? imgTiming :
                           (regReq.addr == OFS_QA_SETUP)  ? imgQaSet  :
                           (regReq.addr == OFS_QA_RESP)   ? respByte_r :
                           (regReq.addr == OFS_QA_CHAL)   ? imgChal   :
                           (regReq.addr == OFS_XCVR)      ? imgXcvr   :
                           (regReq.addr == OFS_IRQ_SUM)   ? irqSum_r  : RST_BYTE;

    // Watchdog setup register: style, prescale, error threshold, enable.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wdogStyle_r <= wdog_style_t'(RST_WD_SETUP[POS_STYLE +: 2]);
            wdogScale_r <= RST_WD_SETUP[POS_SCALE +: 2];
            errCntSet_r <= RST_WD_SETUP[POS_ERRSET +: 2];
            wdogOn_r    <= RST_WD_SETUP[POS_WDOG_ON];
        end else if (wrSetup) begin
            wdogStyle_r <= wdog_style_t'(regReq.wrData[POS_STYLE +: 2]);
            wdogScale_r <= regReq.wrData[POS_SCALE +: 2];
            errCntSet_r <= regReq.wrData[POS_ERRSET +: 2];
            wdogOn_r    <= regReq.wrData[POS_WDOG_ON];
        end
    end

    // Duration field is software writable; the fault counter is not.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            durSel_r   <= RST_DURATION;
            faultCnt_r <= RST_FAULT_CNT;
        end else begin
            if (wrTiming) begin
                durSel_r <= regReq.wrData[POS_DURATION +: 3];
            end
            faultCnt_r <= faultCnt_nxt;
        end
    end

    // QA setup; the effective seed differs from the shown one until written.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            respGen_r   <= RST_QA_SETUP[POS_RESPGEN +: 2];
            polySel_r   <= RST_QA_SETUP[POS_POLY +: 2];
            seedShown_r <= RST_QA_SETUP[POS_SEED +: 4];
            seedEff_r   <= RST_SEED_EFF;
        end else if (wrQaSet) begin
            respGen_r   <= regReq.wrData[POS_RESPGEN +: 2];
            polySel_r   <= regReq.wrData[POS_POLY +: 2];
            seedShown_r <= regReq.wrData[POS_SEED +: 4];
            seedEff_r   <= regReq.wrData[POS_SEED +: 4];
        end
    end

    // The last answer byte is kept so that software can read it back.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            respByte_r <= RST_BYTE;
        end else if (wrResp) begin
            respByte_r <= regReq.wrData;
        end
    end

    // Watchdog run state, timer and question machinery.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r     <= WD_IDLE;
            tickDiv_r   <= 16'h0000;
            tickCnt_r   <= 12'h000;
            respFault_r <= 1'b0;
            respCnt_r   <= 2'h0;
            challenge_r <= 4'h0;
            lfsr_r      <= RST_SEED_EFF;
        end else begin
            state_r     <= state_nxt;
            tickDiv_r   <= tickDiv_nxt;
            tickCnt_r   <= tickCnt_nxt;
            respFault_r <= respFault_nxt;
            respCnt_r   <= respCnt_nxt;
            challenge_r <= challenge_nxt;
            lfsr_r      <= lfsr_nxt;
        end
    end

    // Transceiver status follows its inputs, one cycle late.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            xcvr_r <= '0;
        end else begin
            xcvr_r <= xcvrIn;
        end
    end

    // Summary is registered so reads never see a half-updated group.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqSum_r <= RST_BYTE;
        end else begin
            irqSum_r <= irqSum_nxt;
        end
    end

    // Read data and status outputs, all from flip-flops.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdData_r  <= RST_BYTE;
            regRdValid_r <= 1'b0;
            wdogFault_r  <= 1'b0;
        end else begin
            regRdData_r  <= regReq.rdEn ? regRdData_nxt : regRdData_r;
            regRdValid_r <= regReq.rdEn;
            wdogFault_r  <= faultEvt;
        end
    end

    assign regRdData      = regRdData_r;
    assign regRdValid     = regRdValid_r;
    assign wdogFaultPulse = wdogFault_r;
    assign wdogRunning    = (state_r == WD_RUN);

endmodule : qa_watchdog_status_regs

// *** core/wdog_pkg.sv ***
// Purpose: Shared constants and types for the watchdog status register block.
// Assumes: One 100 MHz clock and byte-wide register frames.
// Notes:   Offsets are byte addresses in the device register space.
package wdog_pkg;

    // Register offsets.
    localparam logic [7:0] OFS_WD_SETUP  = 8'h13;
    localparam logic [7:0] OFS_WD_TIMING = 8'h14;
    localparam logic [7:0] OFS_KICK      = 8'h15;
    localparam logic [7:0] OFS_QA_SETUP  = 8'h2D;
    localparam logic [7:0] OFS_QA_RESP   = 8'h2E;
    localparam logic [7:0] OFS_QA_CHAL   = 8'h2F;
    localparam logic [7:0] OFS_XCVR      = 8'h40;
    localparam logic [7:0] OFS_IRQ_SUM   = 8'h50;

    // Field positions (low bit of each field).
    localparam int unsigned POS_STYLE    = 6;
    localparam int unsigned POS_SCALE    = 4;
    localparam int unsigned POS_ERRSET   = 2;
    localparam int unsigned POS_WDOG_ON  = 0;
    localparam int unsigned POS_DURATION = 5;
    localparam int unsigned POS_FAULTCNT = 1;
    localparam int unsigned POS_RESPGEN  = 6;
    localparam int unsigned POS_POLY     = 4;
    localparam int unsigned POS_SEED     = 0;
    localparam int unsigned POS_RESPERR  = 6;
    localparam int unsigned POS_RESPCNT  = 4;
    localparam int unsigned POS_CHAL     = 0;

    // Reset and load values.
    localparam logic [7:0] RST_WD_SETUP   = 8'h54;
    localparam logic [2:0] RST_DURATION   = 3'h0;
    localparam logic [3:0] RST_FAULT_CNT  = 4'h1;
    localparam logic [3:0] FAULT_CNT_MAX  = 4'hF;
    localparam logic [7:0] RST_QA_SETUP   = 8'h00;
    localparam logic [3:0] RST_SEED_EFF   = 4'h5;
    localparam logic [3:0] CHAL_ON_ENABLE = 4'hC;
    localparam logic [1:0] RESP_CNT_START = 2'h3;
    localparam logic [7:0] KICK_BYTE      = 8'hFF;
    localparam logic [7:0] RST_BYTE       = 8'h00;

    // Timing: one watchdog tick per microsecond, sixteen ticks per duration step.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_TIME_US  = 1;
    localparam int unsigned TICK_CYCLES   = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned BASE_TICKS    = 16;

    typedef enum logic [1:0] {
        STYLE_AUTO    = 2'b00,
        STYLE_TIMEOUT = 2'b01,
        STYLE_WINDOW  = 2'b10,
        STYLE_QA      = 2'b11
    } wdog_style_t;

    typedef enum logic {
        WD_IDLE = 1'b0,
        WD_RUN  = 1'b1
    } wdog_state_t;

    typedef struct packed {
        logic canActive;
        logic busQuiet;
        logic txLowBlock;
    } xcvr_status_t;

    typedef struct packed {
        logic [7:0] grp1;
        logic [7:0] grp2;
        logic [7:0] grp3;
        logic [7:0] busFault;
    } irq_groups_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wrEn;
        logic       rdEn;
        logic [7:0] wrData;
    } reg_req_t;

endpackage : wdog_pkg

// *** verification/qa_watchdog_status_regs_properties.sv ***
// Purpose: Port-level temporal checks for the watchdog status register block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Attached by bind from the testbench top file.
`timescale 1ns/10ps
module qa_watchdog_status_regs_properties (
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire wdog_pkg::reg_req_t     regReq,
    input wire wdog_pkg::xcvr_status_t xcvrIn,
    input wire wdog_pkg::irq_groups_t  irqIn,
    input wire logic [7:0]             regRdData,
    input wire logic                   regRdValid,
    input wire logic                   wdogFaultPulse,
    input wire logic                   wdogRunning
);
    import wdog_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Expected images of the two read-only registers for a given input set.
    function automatic logic [7:0] sumOf(irq_groups_t g);
        sumOf = {|g, |g.grp1, |g.grp2, |g.grp3, |g.busFault, 3'h0};
    endfunction : sumOf
    function automatic logic [7:0] statOf(xcvr_status_t x);
        statOf = {4'h0, x.canActive, x.busQuiet, 1'b0, x.txLowBlock};
    endfunction : statOf

    // Request steps shared by the multi-step properties.
    sequence s_readOf(logic [7:0] a);
        regReq.rdEn && regReq.addr == a;
    endsequence
    sequence s_enWrite;
        regReq.wrEn && regReq.addr == OFS_WD_SETUP && regReq.wrData[POS_WDOG_ON] && !wdogRunning;
    endsequence

    property p_readAnswer; regReq.rdEn |=> regRdValid; endproperty
    a_readAnswer: assert property (p_readAnswer) else $error("read not answered");
    property p_noSpurious; !regReq.rdEn |=> !regRdValid && $stable(regRdData); endproperty
    a_noSpurious: assert property (p_noSpurious) else $error("read data moved");
    // Status and summary pass through one register stage, so look two cycles back.
    property p_statusRead;
        s_readOf(OFS_XCVR) ##1 !$past(rst, 2) |-> regRdData == statOf($past(xcvrIn, 2));
    endproperty
    a_statusRead: assert property (p_statusRead) else $error("status wrong");
    property p_sumRead;
        s_readOf(OFS_IRQ_SUM) ##1 !$past(rst, 2) |-> regRdData == sumOf($past(irqIn, 2));
    endproperty
    a_sumRead: assert property (p_sumRead) else $error("summary wrong");
    property p_unmapped; s_readOf(8'h00) |=> regRdData == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Enable lands one edge after the write and the run state one edge later still.
    property p_enable; s_enWrite |-> ##3 wdogRunning; endproperty
    a_enable: assert property (p_enable) else $error("watchdog did not start");
    property p_disable;
        regReq.wrEn && regReq.addr == OFS_WD_SETUP && !regReq.wrData[POS_WDOG_ON]
            |-> ##3 !wdogRunning;
    endproperty
    a_disable: assert property (p_disable) else $error("watchdog did not stop");
    property p_chalOnEnable;
        s_enWrite ##3 s_readOf(OFS_QA_CHAL) |=> regRdData[5:0] == {RESP_CNT_START, CHAL_ON_ENABLE};
    endproperty
    a_chalOnEnable: assert property (p_chalOnEnable) else $error("question not C3");
    property p_faultRunning; wdogFaultPulse |-> $past(wdogRunning); endproperty
    a_faultRunning: assert property (p_faultRunning) else $error("fault while idle");
endmodule : qa_watchdog_status_regs_properties

// *** verification/host_model.sv ***
// Purpose: Host microcontroller model issuing register frames to the block.
// Assumes: Requests start just after a rising edge and last one cycle.
// Notes:   Released lines show the inverse of the last value, never a stale copy.
`timescale 1ns/10ps
module host_model (
    input wire logic         clk_sys,
    input wire logic [7:0]   regRdData,
    input wire logic         regRdValid,
    output wdog_pkg::reg_req_t regReq
);
    import wdog_pkg::*;

    initial regReq = '0;

    // Every write carries one whole byte.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regReq.addr <= a;
        regReq.wrData <= d;
        regReq.wrEn <= 1'b1;
        @(posedge clk_sys);
        regReq.wrEn <= 1'b0;
        regReq.addr <= ~a;
        regReq.wrData <= ~d;
    endtask : wr

    // A missing valid returns unknown so that the caller's compare fails.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regReq.addr <= a;
        regReq.rdEn <= 1'b1;
        @(posedge clk_sys);
        regReq.rdEn <= 1'b0;
        regReq.addr <= ~a;
        #1 d = (regRdValid === 1'b1) ? regRdData : 8'hXX;
    endtask : rd
endmodule : host_model

// *** verification/test_qa_watchdog_status_regs.sv ***
// Purpose: Self-checking bench for the watchdog status register block.
// Assumes: Shortened tick and step parameters keep expiry within tens of cycles.
// Notes:   Fault pulses are counted here to predict the fault counter.
`timescale 1ns/10ps
module test_qa_watchdog_status_regs;
    import wdog_pkg::*;
    localparam int MAX_CYCLES = 5000;
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    reg_req_t          regReq;
    xcvr_status_t      xcvrIn = '0;
    irq_groups_t       irqIn = '0;
    logic [7:0]        regRdData;
    logic              regRdValid;
    logic              wdogFaultPulse;
    logic              wdogRunning;
    logic [7:0]        rv;
    int                failures = 0;
    int                compares = 0;
    int                faultSeen = 0;
    int                cycles = 0;
    int                snap;
    logic [7:0] rstAddr[9] = '{OFS_WD_SETUP, OFS_WD_TIMING, OFS_KICK, OFS_QA_SETUP,
                               OFS_QA_RESP, OFS_QA_CHAL, OFS_XCVR, OFS_IRQ_SUM, 8'h00};
    logic [7:0] rstVal[9] = '{RST_WD_SETUP, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h00};
    logic [7:0] xcvrExp[3] = '{8'h08, 8'h04, 8'h01};

    always #5 clk_sys = ~clk_sys;

    qa_watchdog_status_regs #(.TICK_DIV(2), .STEP_TICKS(2)) dut (
        .clk_sys(clk_sys), .rst(rst), .regReq(regReq), .xcvrIn(xcvrIn), .irqIn(irqIn),
        .regRdData(regRdData), .regRdValid(regRdValid), .wdogFaultPulse(wdogFaultPulse),
        .wdogRunning(wdogRunning));
    host_model host (.clk_sys(clk_sys), .regRdData(regRdData), .regRdValid(regRdValid),
        .regReq(regReq));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        check(rv, exp);
    endtask : rdChk
    task automatic conclude;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // Fault pulses last one cycle, so count them on every edge; the ceiling cuts hangs.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (wdogFaultPulse === 1'b1) begin
            faultSeen <= faultSeen + 1;
        end
        if (cycles == MAX_CYCLES) begin
            failures++;
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rstAddr[i]) rdChk(rstAddr[i], rstVal[i]);
        $display("test reset values done");
        for (int b = 0; b < 3; b++) begin
            @(posedge clk_sys) xcvrIn <= 3'b100 >> b;
            rdChk(OFS_XCVR, xcvrExp[b]);
        end
        for (int g = 0; g < 4; g++) begin
            @(posedge clk_sys) irqIn <= 32'h0000_0080 << (8 * (3 - g));
            rdChk(OFS_IRQ_SUM, 8'h80 | (8'h40 >> g));
        end
        @(posedge clk_sys) irqIn <= '0;
        xcvrIn <= '0;
        host.wr(OFS_XCVR, 8'hFF);
        rdChk(OFS_XCVR, 8'h00);
        host.wr(OFS_IRQ_SUM, 8'hFF);
        rdChk(OFS_IRQ_SUM, 8'h00);
        host.wr(OFS_WD_TIMING, 8'hFF);
        rdChk(OFS_WD_TIMING, 8'hE2);
        host.wr(OFS_QA_SETUP, 8'hA5);
        rdChk(OFS_QA_SETUP, 8'hA5);
        host.wr(OFS_QA_SETUP, 8'h00);
        $display("test status and access done");
        // Timeout style, prescale 2, period of eight cycles: kicks every four keep it quiet.
        host.wr(OFS_WD_TIMING, 8'h00);
        host.wr(OFS_WD_SETUP, 8'h55);
        snap = faultSeen;
        repeat (10) begin
            host.wr(OFS_KICK, KICK_BYTE);
            repeat (2) @(posedge clk_sys);
        end
        check(8'(faultSeen - snap), 8'h00);
        repeat (5) begin
            host.wr(OFS_KICK, 8'hFE);
            repeat (2) @(posedge clk_sys);
        end
        check(8'(faultSeen > snap), 8'h01);
        host.wr(OFS_WD_SETUP, 8'h54);
        repeat (3) @(posedge clk_sys);
        rdChk(OFS_WD_TIMING, {3'h0, (faultSeen >= 14) ? 4'hF : 4'(1 + faultSeen), 1'b0});
        snap = faultSeen;
        repeat (50) @(posedge clk_sys);
        check(8'(faultSeen - snap), 8'h00);
        host.wr(OFS_WD_SETUP, 8'h55);
        repeat (150) @(posedge clk_sys);
        host.wr(OFS_WD_SETUP, 8'h54);
        repeat (3) @(posedge clk_sys);
        rdChk(OFS_WD_TIMING, 8'h1E);
        $display("test kick and fault count done");
        // Question-and-answer style, long period; good answer to C with count 3 is 0C.
        host.wr(OFS_WD_TIMING, 8'hE0);
        host.wr(OFS_WD_SETUP, 8'hF5);
        // The question loads on the edge that starts the run, one cycle after the enable.
        @(posedge clk_sys);
        rdChk(OFS_QA_CHAL, 8'h3C);
        snap = faultSeen;
        host.wr(OFS_QA_RESP, 8'h00);
        repeat (2) @(posedge clk_sys);
        check(8'(faultSeen - snap), 8'h01);
        rdChk(OFS_QA_CHAL, 8'h7C);
        host.wr(OFS_QA_CHAL, 8'h40);
        rdChk(OFS_QA_CHAL, 8'h3C);
        host.wr(OFS_QA_RESP, 8'h0C);
        rdChk(OFS_QA_CHAL, 8'h2C);
        rdChk(OFS_QA_RESP, 8'h0C);
        $display("test question and answer done");
        conclude();
    end
endmodule : test_qa_watchdog_status_regs

bind qa_watchdog_status_regs qa_watchdog_status_regs_properties chk (
    .clk_sys(clk_sys), .rst(rst), .regReq(regReq), .xcvrIn(xcvrIn), .irqIn(irqIn),
    .regRdData(regRdData), .regRdValid(regRdValid), .wdogFaultPulse(wdogFaultPulse),
    .wdogRunning(wdogRunning));
